// [logic/jtdap_pkg.sv]
package jtdap_pkg;

    // Instruction register geometry and fixed values.
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam logic [3:0]  INS_EXTEST    = 4'h0;
    localparam logic [3:0]  INS_SAMPLE    = 4'h1;
    localparam logic [3:0]  INS_PRELOAD   = 4'h2;
    localparam logic [3:0]  INS_INTEST    = 4'h4;
    localparam logic [3:0]  INS_CLAMP     = 4'h5;
    localparam logic [3:0]  INS_HIGHZ     = 4'h6;
    localparam logic [3:0]  INS_PARK      = 4'h7;
    localparam logic [3:0]  INS_ABORT     = 4'h8;
    localparam logic [3:0]  INS_PORT_ACC  = 4'hA;
    localparam logic [3:0]  INS_AP_ACC    = 4'hB;
    localparam logic [3:0]  INS_IDCODE    = 4'hE;
    localparam logic [3:0]  INS_BYPASS    = 4'hF;

    // Data chain lengths.
    localparam int          ACC_W         = 35;
    localparam int          ID_W          = 32;
    localparam logic [31:0] IDCODE_DFLT   = 32'h0000_0001; // Arbitrary value; bit 0 reads one.

    // Tap controller states, Gray coded along the main path.
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h3, ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6, ST_EX1_DR  = 4'h7, ST_PAU_DR  = 4'h5, ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hC, ST_SEL_IR  = 4'hD, ST_CAP_IR  = 4'hF, ST_SH_IR   = 4'hE,
        ST_EX1_IR  = 4'hA, ST_PAU_IR  = 4'hB, ST_EX2_IR  = 4'h9, ST_UPD_IR  = 4'h8
    } jtdap_state_t;

    // Which data chain sits between serial input and output.
    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_IDCODE, SEL_ABORT, SEL_PORT, SEL_AP, SEL_BSCAN
    } jtdap_sel_t;

    // Update strobe with the word that a 35-bit chain delivered.
    typedef struct packed {
        logic              abort_upd;
        logic              port_upd;
        logic              ap_upd;
        logic [ACC_W-1:0]  data;
    } jtdap_upd_t;

endpackage

// [logic/jtdap_tap.sv]
`timescale 1ns/1ps
module jtdap_tap #(
    parameter logic [31:0] IDCODE_VAL = jtdap_pkg::IDCODE_DFLT, // Arbitrary value.
    parameter bit          HAS_BSCAN  = 1'b0,
    parameter int          BSR_W      = 8
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     debug_tap_reset_n,
    input  wire logic                     dbg_clk,
    input  wire logic                     debug_mode_select,
    input  wire logic                     debug_serial_in,
    output logic                          debug_serial_out,
    output logic                          debug_serial_out_oe,
    input  wire logic                     debug_reset_req,
    input  wire logic [jtdap_pkg::ACC_W-1:0] acc_capture,
    output jtdap_pkg::jtdap_upd_t         upd_o,
    output logic                          ap_regs_rst,
    input  wire logic [BSR_W-1:0]         bsr_pins_in,
    output logic [BSR_W-1:0]              bsr_out,
    output logic                          bsr_park,
    output logic [jtdap_pkg::IR_W-1:0]    cur_instr,
    output jtdap_pkg::jtdap_state_t       tap_state
);
    import jtdap_pkg::*;

    // The boundary chain shares the 35-bit data shifter, so it cannot be longer than that.
    if (BSR_W < 1 || BSR_W > ACC_W) begin : g_bsr_w_bad
        $error("BSR_W must lie between one and the access chain length");
    end

    // Link pins come from another clock domain; two flops before any use.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       tck_d_r;
    logic [1:0] trst_sync_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            tck_d_r <= 1'b0;
        end else begin
            sync1_r <= {dbg_clk, debug_mode_select, debug_serial_in};
            sync2_r <= sync1_r;
            tck_d_r <= sync2_r[2];
        end
    end

    // Tap reset pin is asynchronous in assertion and released synchronously.
    always_ff @(posedge clk_sys or negedge debug_tap_reset_n) begin
        if (!debug_tap_reset_n) begin
            trst_sync_r <= 2'h0;
        end else begin
            trst_sync_r <= {trst_sync_r[0], 1'b1};
        end
    end

    wire logic tap_rst_n = rst_n & debug_tap_reset_n & trst_sync_r[1];
    wire logic tms_s     = sync2_r[1];
    wire logic tdi_s     = sync2_r[0];
    wire logic tck_rise  = sync2_r[2] & ~tck_d_r;
    wire logic tck_fall  = ~sync2_r[2] & tck_d_r;

    // Next-state function of the standard sixteen-state controller.
    function automatic jtdap_state_t next_st(input jtdap_state_t s, input logic m);
        case (s)
            ST_RESET:  next_st = m ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_st = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_st = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_st = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_st = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_st = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_st = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_st = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_st = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_st = m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_st = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_st = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_st = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_st = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_st = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_st = m ? ST_SEL_DR : ST_IDLE;
            default:   next_st = ST_RESET;
        endcase
    endfunction

    // Instruction decode; unimplemented and reserved codes fall to bypass.
    function automatic jtdap_sel_t decode(input logic [3:0] ins);
        case (ins)
            INS_ABORT:    decode = SEL_ABORT;
            INS_PORT_ACC: decode = SEL_PORT;
            INS_AP_ACC:   decode = SEL_AP;
            INS_IDCODE:   decode = SEL_IDCODE;
            INS_EXTEST, INS_SAMPLE, INS_PRELOAD, INS_INTEST, INS_CLAMP, INS_HIGHZ, INS_PARK:
                decode = HAS_BSCAN ? SEL_BSCAN : SEL_BYPASS;
            default:      decode = SEL_BYPASS;
        endcase
    endfunction

    jtdap_state_t     st_r;
    logic [IR_W-1:0]  ir_sh_r;
    logic [IR_W-1:0]  ir_r;
    logic [ACC_W-1:0] dr_sh_r;
    logic [BSR_W-1:0] bsr_upd_r;
    logic             tdo_r;
    logic             oe_r;
    jtdap_upd_t       upd_r;
    logic             ap_rst_r;

    wire jtdap_state_t st_nxt   = next_st(st_r, tms_s);
    wire jtdap_sel_t   sel      = decode(ir_r);
    wire logic         shifting = (st_r == ST_SH_DR) || (st_r == ST_SH_IR);
    wire logic         st_upd   = tck_rise && (st_r == ST_UPD_DR);

    // Chain length follows the selected register.
    wire logic [5:0] dr_len = (sel == SEL_BYPASS) ? 6'h01 :
                              (sel == SEL_IDCODE) ? 6'(ID_W) :
                              (sel == SEL_BSCAN)  ? 6'(BSR_W) : 6'(ACC_W);

    // Controller and instruction register; only these and the five-ones helper see the tap reset.
    always_ff @(posedge clk_sys or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            st_r <= ST_RESET;
            ir_r <= INS_IDCODE;
        end else if (tck_rise) begin
            st_r <= st_nxt;
            // Load IDCODE on entry so the reset state never shows a stale instruction.
            if (st_nxt == ST_RESET) begin
                ir_r <= INS_IDCODE;
            end else if (st_r == ST_UPD_IR) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    // Instruction shift chain, LSB out, serial input into bit three.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r <= IR_CAPTURE;
        end else if (tck_rise && st_r == ST_CAP_IR) begin
            ir_sh_r <= IR_CAPTURE;
        end else if (tck_rise && st_r == ST_SH_IR) begin
            ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
        end
    end

    // Data chain: capture picks the selected source, shift enters at the chain's own MSB.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dr_sh_r <= '0;
        end else if (tck_rise && st_r == ST_CAP_DR) begin
            case (sel)
                SEL_BYPASS: dr_sh_r <= '0;
                SEL_IDCODE: dr_sh_r <= {3'h0, IDCODE_VAL};
                SEL_BSCAN:  dr_sh_r <= ACC_W'(bsr_pins_in);
                default:    dr_sh_r <= acc_capture;
            endcase
        end else if (tck_rise && st_r == ST_SH_DR) begin
            dr_sh_r <= (dr_sh_r >> 1) | (ACC_W'(tdi_s) << (dr_len - 6'd1));
        end
    end

    // Serial output changes on the falling edge so the probe samples it on the rising one.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end else if (tck_fall) begin
            tdo_r <= (st_r == ST_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
            oe_r  <= shifting;
        end
    end

    // Update strobes; bypass and IDCODE ignore shifted-in data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            upd_r     <= '0;
            bsr_upd_r <= '0;
        end else begin
            upd_r.abort_upd <= st_upd && sel == SEL_ABORT;
            upd_r.port_upd  <= st_upd && sel == SEL_PORT;
            upd_r.ap_upd    <= st_upd && sel == SEL_AP;
            if (st_upd) begin
                upd_r.data <= dr_sh_r;
            end
            if (st_upd && sel == SEL_BSCAN) begin
                bsr_upd_r <= dr_sh_r[BSR_W-1:0];
            end
        end
    end

    // The access-port reset follows the debug reset request; port registers use rst_n only.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ap_rst_r <= 1'b1;
        end else begin
            ap_rst_r <= debug_reset_req;
        end
    end

    // Park: outputs inactive, values still from the scan cells.
    logic park_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            park_r <= 1'b0;
        end else begin
            park_r <= HAS_BSCAN && ir_r == INS_PARK;
        end
    end

    assign debug_serial_out    = tdo_r;
    assign debug_serial_out_oe = oe_r;
    assign upd_o               = upd_r;
    assign ap_regs_rst         = ap_rst_r;
    assign bsr_out             = bsr_upd_r;
    assign bsr_park            = park_r;
    assign cur_instr           = ir_r;
    assign tap_state           = st_r;

    // Checks.
    a_ir_capture: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_CAP_IR) |=> ir_sh_r == IR_CAPTURE)
        else $error("capture-IR pattern wrong");
    a_ir_shift: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_SH_IR) |=> ir_sh_r == {$past(tdi_s), $past(ir_sh_r[3:1])})
        else $error("IR shift wrong");
    a_ir_update: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_UPD_IR) |=> ir_r == $past(ir_sh_r))
        else $error("IR update lost");
    a_reset_idcode: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (st_r == ST_RESET) |-> ir_r == INS_IDCODE)
        else $error("reset state did not select IDCODE");
    a_bypass_cap: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_CAP_DR && sel == SEL_BYPASS) |=> dr_sh_r == '0)
        else $error("bypass capture not zero");
    a_id_cap: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_CAP_DR && sel == SEL_IDCODE) |=> dr_sh_r[31:0] == IDCODE_VAL)
        else $error("IDCODE capture wrong");
    a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (st_r == ST_IDLE && !tms_s) |=> !upd_r.ap_upd && !upd_r.port_upd && !upd_r.abort_upd)
        else $error("idle caused an update");
    a_decode_res: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (ir_r == 4'h9 || ir_r[3:1] == 3'h6) |-> sel == SEL_BYPASS)
        else $error("reserved code not bypass");
    a_decode_acc: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && st_r == ST_UPD_DR && ir_r == INS_AP_ACC) |=> upd_r.ap_upd && !upd_r.port_upd)
        else $error("AP update strobe missing");
    a_tms_reset: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (tck_rise && tms_s && st_r == ST_SEL_IR) |=> st_r == ST_RESET)
        else $error("select-IR with mode high missed reset");

    // Helper for the five-ones path: rising tap edges seen in a row with mode high.
    // It saturates at five, so a long run of ones keeps the check armed.
    logic [2:0] ones_r;
    always_ff @(posedge clk_sys or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ones_r <= 3'h0;
        end else if (tck_rise) begin
            ones_r <= tms_s ? ((ones_r == 3'h5) ? 3'h5 : ones_r + 3'h1) : 3'h0;
        end
    end

    // Named steps of the serial path.
    sequence s_fall_sh_ir;
        tck_fall && st_r == ST_SH_IR;
    endsequence
    sequence s_rise_bypass_sh;
        tck_rise && st_r == ST_SH_DR && sel == SEL_BYPASS;
    endsequence

    a_five_ones: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        (ones_r == 3'h5) |-> st_r == ST_RESET)
        else $error("five high mode cycles missed reset");
    a_tdo_ir_lsb: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        s_fall_sh_ir |=> debug_serial_out == $past(ir_sh_r[0]))
        else $error("serial output not the IR chain LSB");
    a_bypass_shift: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        s_rise_bypass_sh |=> dr_sh_r[0] == $past(tdi_s))
        else $error("bypass bit not the serial input");
    a_oe_shift: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        tck_fall |=> debug_serial_out_oe == $past(shifting))
        else $error("output enable does not follow shifting");
endmodule // jtdap_tap

// [bench/jtdap_probe.sv]
`timescale 1ns/1ps
// Behavioural debug probe that drives the tap pins and samples the serial output.
module jtdap_probe (
    input  wire logic clk_sys,
    input  wire logic debug_serial_out,
    output logic      dbg_clk,
    output logic      debug_mode_select,
    output logic      debug_serial_in
);
    // The tap clock rests high between ticks; idle may keep it running.
    initial begin
        dbg_clk = 1'b0;
        debug_mode_select = 1'b1;
        debug_serial_in = 1'b0;
    end

    // One tap clock of 800 ns: low for five system clocks, high for three.
    // Output is read at the end of the low phase, well after the design moved it.
    // Outside shifts the serial input toggles, so stale data is never mistaken for real.
    task automatic tick(input logic tms, input logic tdi, input logic shift, output logic tdo);
        @(posedge clk_sys);
        dbg_clk           <= 1'b0;
        debug_mode_select <= tms;
        debug_serial_in   <= shift ? tdi : ~debug_serial_in;
        repeat (5) @(posedge clk_sys);
        tdo = debug_serial_out;
        dbg_clk <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask

    // Full scan from idle back to idle; bits go in and come out least significant first.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic b;
        dout = '0;
        tick(1'b1, 1'b0, 1'b0, b);
        if (ir) tick(1'b1, 1'b0, 1'b0, b);
        tick(1'b0, 1'b0, 1'b0, b);
        tick(1'b0, 1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], 1'b1, b);
            dout[i] = b;
        end
        tick(1'b1, 1'b0, 1'b0, b);
        tick(1'b0, 1'b0, 1'b0, b);
        // The last rising edge still sits in the pin synchronisers; let it land.
        repeat (3) @(posedge clk_sys);
    endtask
endmodule // jtdap_probe

// [bench/jtdap_tap_test.sv]
`timescale 1ns/1ps
module jtdap_tap_test;
    import jtdap_pkg::*;
    localparam logic [31:0] ID_VAL  = 32'h1234_5679;  // Arbitrary value with bit 0 set.
    localparam logic [34:0] CAP_VAL = 35'h5_A5C3_0F12;
    localparam logic [63:0] DIN     = 64'h0000_00B6_9E3D_71C5;

    logic         clk_sys = 1'b0;
    logic         rst_n, debug_tap_reset_n, debug_reset_req, b;
    logic         dbg_clk, debug_mode_select, debug_serial_in;
    logic         debug_serial_out, debug_serial_out_oe, ap_regs_rst, bsr_park;
    logic [3:0]   cur_instr;
    logic [7:0]   bsr_out;
    jtdap_upd_t   upd_o;
    jtdap_state_t tap_state;
    logic [2:0]   upd_seen = '0;
    logic [34:0]  upd_data;
    int           failures = 0;
    int           num_checks = 0;

    // System clock at 10 MHz.
    always #50 clk_sys = ~clk_sys;

    jtdap_tap #(.IDCODE_VAL(ID_VAL)) u_dut (
        .clk_sys, .rst_n, .debug_tap_reset_n, .dbg_clk, .debug_mode_select,
        .debug_serial_in, .debug_serial_out, .debug_serial_out_oe, .debug_reset_req,
        .acc_capture(CAP_VAL), .upd_o, .ap_regs_rst, .bsr_pins_in(8'hA5), .bsr_out,
        .bsr_park, .cur_instr, .tap_state
    );

    jtdap_probe u_probe (.clk_sys, .debug_serial_out, .dbg_clk, .debug_mode_select,
                         .debug_serial_in);

    // Collect update strobes; a second strobe kind in one scan would show as extra bits.
    always @(posedge clk_sys) begin
        if (upd_o.abort_upd || upd_o.port_upd || upd_o.ap_upd) begin
            upd_seen <= upd_seen | {upd_o.abort_upd, upd_o.port_upd, upd_o.ap_upd};
            upd_data <= upd_o.data;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected chain length per instruction; boundary codes fall to bypass when absent.
    function automatic int chain_len(input logic [3:0] c);
        case (c)
            INS_ABORT, INS_PORT_ACC, INS_AP_ACC: return ACC_W;
            INS_IDCODE: return ID_W;
            default: return 1;
        endcase
    endfunction

    // A 40-bit data scan reveals both the captured value and the chain length.
    task automatic dr_check(input logic [3:0] code);
        int          len;
        logic [63:0] cap, dout, exp;
        len = chain_len(code);
        cap = (len == ACC_W) ? 64'(CAP_VAL) : (len == ID_W) ? 64'(ID_VAL) : 64'h0;
        exp = ((DIN << len) | cap) & 64'hFF_FFFF_FFFF;
        upd_seen = '0;
        u_probe.scan(1'b0, 40, DIN, dout);
        check(dout, exp);
        check(upd_seen, {code == INS_ABORT, code == INS_PORT_ACC, code == INS_AP_ACC});
        if (len == ACC_W) check(upd_data, DIN[39:5]);
    endtask

    task automatic wait_state(input jtdap_state_t st);
        repeat (3) @(posedge clk_sys);
        check(tap_state, st);
    endtask

    task automatic t_reset_state();
        check(cur_instr, INS_IDCODE);
        check(ap_regs_rst, 1'b0);
        wait_state(ST_RESET);
        u_probe.tick(1'b0, 1'b0, 1'b0, b);
        wait_state(ST_IDLE);
        dr_check(INS_IDCODE);
    endtask

    // Every instruction code, with eight bits so the shifted-in nibble returns too.
    task automatic t_decode();
        logic [63:0] dout;
        logic [3:0]  code;
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            u_probe.scan(1'b1, 8, {56'h0, code, ~code}, dout);
            check(dout[7:0], {~code, IR_CAPTURE});
            check(cur_instr, code);
            check({bsr_park, bsr_out}, 9'h000);
            dr_check(code);
        end
    endtask

    // Tap reset in mid-shift touches only state and instruction.
    task automatic t_tap_reset();
        upd_seen = '0;
        for (int i = 0; i < 5; i++) u_probe.tick(i < 2, 1'b1, i > 3, b);
        debug_tap_reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(tap_state, ST_RESET);
        check(cur_instr, INS_IDCODE);
        check({ap_regs_rst, upd_seen}, 4'h0);
        debug_tap_reset_n <= 1'b1;
        u_probe.tick(1'b0, 1'b0, 1'b0, b);
        debug_reset_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(ap_regs_rst, 1'b1);
        debug_reset_req <= 1'b0;
        wait_state(ST_IDLE);
        check({ap_regs_rst, cur_instr}, {1'b0, INS_IDCODE});
    endtask

    // Five high mode cycles from Shift-DR reach reset through Update-DR and its strobe.
    task automatic t_five_ones();
        logic [63:0] dout;
        u_probe.scan(1'b1, 4, 64'(INS_PORT_ACC), dout);
        upd_seen = '0;
        u_probe.tick(1'b1, 1'b0, 1'b0, b);
        u_probe.tick(1'b0, 1'b0, 1'b0, b);
        u_probe.tick(1'b0, 1'b0, 1'b0, b);
        repeat (5) u_probe.tick(1'b1, 1'b0, 1'b0, b);
        wait_state(ST_RESET);
        check({upd_seen, cur_instr}, {3'b010, INS_IDCODE});
        u_probe.tick(1'b0, 1'b0, 1'b0, b);
    endtask

    // Resting in idle with the tap clock running does nothing.
    task automatic t_idle();
        upd_seen = '0;
        repeat (12) u_probe.tick(1'b0, 1'b0, 1'b0, b);
        wait_state(ST_IDLE);
        check({upd_seen, cur_instr, debug_serial_out_oe}, {3'b000, INS_IDCODE, 1'b0});
    endtask

    // Watchdog cuts a hang short.
    initial begin
        repeat (50000) @(posedge clk_sys);
        failures++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        debug_tap_reset_n = 1'b0;
        debug_reset_req = 1'b0;
        repeat (6) @(posedge clk_sys);
        check(ap_regs_rst, 1'b1);
        rst_n <= 1'b1;
        debug_tap_reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset_state();
        t_decode();
        t_tap_reset();
        t_five_ones();
        t_idle();
        test_done();
    end
endmodule // jtdap_tap_test
